/* adc_cfg_pkg.sv */
// Package with control word layout, reset values and timing counts
package adc_cfg_pkg;
    localparam int WORD_W = 12;
    localparam int ADDR_W = 2;
    localparam logic [1:0] ADDR_INPUT_SEL = 2'h0;
    localparam logic [1:0] ADDR_FIFO_CFG = 2'h1;
    // Input select word fields
    localparam int POS_PICK_LOW = 3;
    localparam int POS_PICK_HIGH = 4;
    localparam int POS_DIFF_LOW = 5;
    localparam int POS_DIFF_HIGH = 6;
    localparam int POS_SCAN = 7;
    localparam int POS_TEST_LOW = 8;
    localparam int POS_TEST_HIGH = 9;
    localparam logic [11:0] INPUT_SEL_RESET = 12'h020;
    // Fifo config word fields
    localparam int POS_SOFT_RESET = 0;
    localparam int POS_FIFO_CLEAR = 1;
    localparam int POS_THR_LOW = 2;
    localparam int POS_THR_HIGH = 3;
    localparam int POS_FLAG_KIND = 4;
    localparam int POS_FLAG_POL = 5;
    localparam logic [11:0] FIFO_CFG_RESET = 12'h030;
    // Start-up after soft reset, in conversion clocks
    localparam int STARTUP_CYCLES = 5;
    localparam int FIFO_DEPTH = 16;

    typedef enum logic [1:0] {
        SRC_NORMAL = 2'h0,
        SRC_REF_HIGH = 2'h1,
        SRC_REF_MID = 2'h2,
        SRC_REF_LOW = 2'h3
    } conv_source_t;

    typedef enum logic [2:0] {
        SEL_POS_SE = 3'h0,
        SEL_NEG_SE = 3'h1,
        SEL_DIFF = 3'h2,
        SEL_SCAN = 3'h3,
        SEL_RESERVED = 3'h4
    } input_mode_t;

    typedef enum logic [1:0] {
        ST_STARTUP = 2'h0,
        ST_RUN = 2'h1
    } run_state_t;

    function automatic logic [4:0] thr_level(input logic [1:0] code, input logic two_ch);
        case (code)
            2'h0: thr_level = two_ch ? 5'h02 : 5'h01;
            2'h1: thr_level = 5'h04;
            2'h2: thr_level = 5'h08;
            default: thr_level = two_ch ? 5'h0C : 5'h0E;
        endcase
    endfunction : thr_level
endpackage : adc_cfg_pkg

/* flag_if.sv */
// Interface carrying fill level and flag settings to the flag generator
`timescale 1ns/100ps
interface flag_if;
    logic [4:0] fill;
    logic [4:0] level;
    logic pulse_kind;
    logic active_high;
    logic flag;
    modport ctrl (output fill, output level, output pulse_kind, output active_high, input flag);
    modport gen (input fill, input level, input pulse_kind, input active_high, output flag);
endinterface : flag_if

/* ready_flag_gen.sv */
// Samples-ready flag generator: threshold compare, kind and polarity
`timescale 1ns/100ps
module ready_flag_gen
    import adc_cfg_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    flag_if.gen fi
);
    logic reached_r;
    logic reached_nxt;
    logic flag_r;
    logic flag_nxt;

    always_comb begin
        reached_nxt = fi.fill >= fi.level;
        // Pulse marks only the crossing, so one interrupt per threshold
        if (fi.pulse_kind) begin
            flag_nxt = reached_nxt && !reached_r;
        end else begin
            flag_nxt = reached_nxt;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reached_r <= 1'b0;
            flag_r <= 1'b0;
        end else begin
            reached_r <= reached_nxt;
            flag_r <= flag_nxt;
        end
    end

    assign fi.flag = fi.active_high ? flag_r : !flag_r;
endmodule : ready_flag_gen

/* adc_input_and_fifo_control.sv */
// Control words, input selection and sample FIFO of the converter
`timescale 1ns/100ps
// Function
// - Input config comes from bits 3 to 7 of the input select word.
// - All selection zero: low pick bit picks positive or negative single-ended.
// - Only low differential bit set: convert positive minus negative differentially.
// - Scan with pick 01: alternate positive and negative, positive first.
// - Test bits 8-9 pick normal, upper, mid or lower reference.
// - Fifo config word is write-only, no readback.
// - Soft reset bit restores both words, clears FIFO and offset.
// - Five clocks after soft reset before first sample enters FIFO.
// - Fifo clear bit empties FIFO, other fields take the written values.
// - Threshold field sets fill level that asserts samples-ready.
// - Threshold codes mean 1,4,8,14 or 2,4,8,12 samples.
// - Kind bit: 0 static level, 1 pulse.
// - Polarity bit: 1 active high, 0 active low.
module adc_input_and_fifo_control
    import adc_cfg_pkg::*;
#(
    parameter int DATA_W = 10,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [WORD_W-1:0] wr_data,
    input wire logic [DATA_W-1:0] positive_analog_input,
    input wire logic [DATA_W-1:0] negative_analog_input,
    input wire logic [DATA_W-1:0] upper_reference_level,
    input wire logic [DATA_W-1:0] lower_reference_level,
    input wire logic sample_tick,
    output logic [DATA_W-1:0] rd_data,
    output logic fifo_empty,
    output logic samples_ready_flag,
    output logic [2:0] input_mode,
    output logic [1:0] conv_source,
    output logic offset_clear
);
    if (DEPTH != 16 || DATA_W < 2) begin : g_bad_params
        $error("Unsupported FIFO depth or data width");
    end

    localparam int PW = $clog2(DEPTH);

    logic [WORD_W-1:0] sel_r;
    logic [WORD_W-1:0] sel_nxt;
    logic [WORD_W-1:0] cfg_r;
    logic [WORD_W-1:0] cfg_nxt;
    run_state_t state_r;
    run_state_t state_nxt;
    logic [2:0] wait_r;
    logic [2:0] wait_nxt;
    logic scan_neg_r;
    logic scan_neg_nxt;
    logic [PW-1:0] wp_r;
    logic [PW-1:0] wp_nxt;
    logic [PW-1:0] rp_r;
    logic [PW-1:0] rp_nxt;
    logic [PW:0] cnt_r;
    logic [PW:0] cnt_nxt;
    logic [DATA_W-1:0] mem_r [DEPTH];
    logic [DATA_W-1:0] rd_data_r;
    logic [DATA_W-1:0] rd_data_nxt;
    logic off_clr_r;
    logic off_clr_nxt;

    logic soft_rst;
    logic fifo_clr;
    logic wr_sel;
    logic wr_cfg;
    logic [4:0] sel_field;
    input_mode_t mode;
    logic [DATA_W-1:0] sample;
    logic push;
    logic pop;
    flag_if fi ();

    assign wr_sel = wr_strobe && reg_addr == ADDR_INPUT_SEL;
    assign wr_cfg = wr_strobe && reg_addr == ADDR_FIFO_CFG;
    assign soft_rst = wr_cfg && wr_data[POS_SOFT_RESET];
    assign fifo_clr = wr_cfg && wr_data[POS_FIFO_CLEAR];

    // Selection decode; any reserved pattern converts nothing
    assign sel_field = sel_r[POS_SCAN:POS_PICK_LOW];
    always_comb begin
        case (sel_field)
            5'h00: mode = SEL_POS_SE;
            5'h01: mode = SEL_NEG_SE;
            5'h04: mode = SEL_DIFF;
            5'h11: mode = SEL_SCAN;
            default: mode = SEL_RESERVED;
        endcase
    end

    function automatic logic [DATA_W-1:0] mid_ref(input logic [DATA_W-1:0] a,
                                                   input logic [DATA_W-1:0] b);
        logic [DATA_W:0] s;
        s = {1'b0, a} + {1'b0, b};
        mid_ref = s[DATA_W:1];
    endfunction : mid_ref

    always_comb begin
        case (conv_source_t'(sel_r[POS_TEST_HIGH:POS_TEST_LOW]))
            SRC_REF_HIGH: sample = upper_reference_level;
            SRC_REF_MID: sample = mid_ref(upper_reference_level, lower_reference_level);
            SRC_REF_LOW: sample = lower_reference_level;
            default: begin
                case (mode)
                    SEL_NEG_SE: sample = negative_analog_input;
                    SEL_DIFF: sample = DATA_W'(positive_analog_input - negative_analog_input);
                    SEL_SCAN: sample = scan_neg_r ? negative_analog_input
                                                  : positive_analog_input;
                    default: sample = positive_analog_input;
                endcase
            end
        endcase
    end

    // Full FIFO drops new samples rather than overwrite unread data
    assign push = sample_tick && state_r == ST_RUN && mode != SEL_RESERVED
                  && cnt_r != (PW+1)'(DEPTH) && !soft_rst && !fifo_clr;
    assign pop = rd_strobe && cnt_r != '0 && !soft_rst && !fifo_clr;

    always_comb begin
        sel_nxt = sel_r;
        cfg_nxt = cfg_r;
        state_nxt = state_r;
        wait_nxt = wait_r;
        scan_neg_nxt = scan_neg_r;
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        cnt_nxt = cnt_r;
        rd_data_nxt = rd_data_r;
        off_clr_nxt = 1'b0;
        if (wr_sel) begin
            sel_nxt = wr_data;
            scan_neg_nxt = 1'b0;
        end
        if (wr_cfg) begin
            // Strobe bits self-clear; they act only on the write
            cfg_nxt = wr_data & ~12'h003;
        end
        if (state_r == ST_STARTUP) begin
            if (wait_r == 3'(STARTUP_CYCLES - 1)) begin
                state_nxt = ST_RUN;
            end else begin
                wait_nxt = wait_r + 3'h1;
            end
        end
        if (push) begin
            wp_nxt = wp_r + PW'(1);
            if (mode == SEL_SCAN) begin
                scan_neg_nxt = !scan_neg_r;
            end
        end
        if (pop) begin
            rd_data_nxt = mem_r[rp_r];
            rp_nxt = rp_r + PW'(1);
        end
        cnt_nxt = cnt_r + (PW+1)'(push) - (PW+1)'(pop);
        if (fifo_clr) begin
            wp_nxt = '0;
            rp_nxt = '0;
            cnt_nxt = '0;
        end
        if (soft_rst) begin
            sel_nxt = INPUT_SEL_RESET;
            cfg_nxt = FIFO_CFG_RESET;
            wp_nxt = '0;
            rp_nxt = '0;
            cnt_nxt = '0;
            scan_neg_nxt = 1'b0;
            off_clr_nxt = 1'b1;
            state_nxt = ST_STARTUP;
            wait_nxt = '0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sel_r <= INPUT_SEL_RESET;
            cfg_r <= FIFO_CFG_RESET;
            state_r <= ST_STARTUP;
            wait_r <= '0;
            scan_neg_r <= 1'b0;
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            rd_data_r <= '0;
            off_clr_r <= 1'b0;
        end else begin
            sel_r <= sel_nxt;
            cfg_r <= cfg_nxt;
            state_r <= state_nxt;
            wait_r <= wait_nxt;
            scan_neg_r <= scan_neg_nxt;
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
            rd_data_r <= rd_data_nxt;
            off_clr_r <= off_clr_nxt;
        end
    end

    // Sample storage carries no reset; pointers define validity
    always_ff @(posedge mclk) begin
        if (push) begin
            mem_r[wp_r] <= sample;
        end
    end

    assign fi.fill = cnt_r;
    // Autoscan fills with two inputs, so it takes the two-channel levels
    assign fi.level = thr_level(cfg_r[POS_THR_HIGH:POS_THR_LOW], mode == SEL_SCAN);
    assign fi.pulse_kind = cfg_r[POS_FLAG_KIND];
    assign fi.active_high = cfg_r[POS_FLAG_POL];

    ready_flag_gen u_flag (
        .mclk(mclk),
        .rst_n(rst_n),
        .fi(fi)
    );

    assign samples_ready_flag = fi.flag;
    assign rd_data = rd_data_r;
    assign fifo_empty = cnt_r == '0;
    assign input_mode = mode;
    assign conv_source = sel_r[POS_TEST_HIGH:POS_TEST_LOW];
    assign offset_clear = off_clr_r;
endmodule : adc_input_and_fifo_control

/* adc_ctrl_monitor.sv */
// Checker of control word effects at the block ports
`timescale 1ns/100ps
module adc_ctrl_monitor
    import adc_cfg_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic wr_strobe,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [WORD_W-1:0] wr_data,
    input wire logic fifo_empty,
    input wire logic samples_ready_flag,
    input wire logic [2:0] input_mode,
    input wire logic [1:0] conv_source,
    input wire logic offset_clear
);
    logic w0;
    logic w1;
    logic [2:0] dec;
    assign w0 = wr_strobe && reg_addr == ADDR_INPUT_SEL;
    assign w1 = wr_strobe && reg_addr == ADDR_FIFO_CFG;
    always_comb begin
        case (wr_data[7:3])
            5'h00: dec = 3'h0;
            5'h01: dec = 3'h1;
            5'h04: dec = 3'h2;
            5'h11: dec = 3'h3;
            default: dec = 3'h4;
        endcase
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    a_mode_write: assert property (
        w0 |=> input_mode == $past(dec)) else $error("Input mode off");
    a_src_follow: assert property (
        w0 |=> conv_source == $past(wr_data[9:8])) else $error("Source off");
    a_soft_restore: assert property (
        w1 && wr_data[0] |=> input_mode == 3'h2 && conv_source == 2'h0 && fifo_empty)
        else $error("Soft reset incomplete");
    a_offset_pulse: assert property (
        w1 && wr_data[0] |-> ##[1:2] offset_clear) else $error("No offset clear");
    a_clear_empty: assert property (
        w1 && wr_data[1] |=> fifo_empty) else $error("Clear left samples");
    a_startup_hold: assert property (
        w1 && wr_data[0] |=> fifo_empty [*5]) else $error("Stored in start-up");
    a_flag_idle: assert property (
        w1 && wr_data[0] |=> ##1 !samples_ready_flag) else $error("Flag set when empty");
    a_flag_low: assert property (
        w1 && wr_data[5:0] == 6'h02 |=> ##1 samples_ready_flag) else $error("Low flag off");
    c_soft: cover property (w1 && wr_data[0]);
    c_scan: cover property (input_mode == 3'h3);
    c_flag: cover property ($rose(samples_ready_flag));
endmodule : adc_ctrl_monitor

bind adc_input_and_fifo_control adc_ctrl_monitor adc_ctrl_monitor_inst (
    .mclk(mclk), .rst_n(rst_n), .wr_strobe(wr_strobe), .reg_addr(reg_addr),
    .wr_data(wr_data), .fifo_empty(fifo_empty), .samples_ready_flag(samples_ready_flag),
    .input_mode(input_mode), .conv_source(conv_source), .offset_clear(offset_clear));

/* host_model.sv */
// Host side of the parallel bus: control writes and sample pops
`timescale 1ns/100ps
module host_model (
    input wire logic mclk,
    output logic wr_strobe = 1'b0,
    output logic rd_strobe = 1'b0,
    output logic [1:0] reg_addr = 2'h0,
    output logic [11:0] wr_data = 12'h000
);
    // Callers pass selection and config words, reserved patterns included
    task wr(input logic [1:0] a, input logic [11:0] d);
        reg_addr = a;
        wr_data = d;
        wr_strobe = 1'b1;
        @(posedge mclk);
        #1;
        wr_strobe = 1'b0;
        // Released bus must not look like the last word
        wr_data = ~d;
        @(posedge mclk);
        #1;
    endtask : wr
    task pop();
        rd_strobe = 1'b1;
        @(posedge mclk);
        #1;
        rd_strobe = 1'b0;
        @(posedge mclk);
        #1;
    endtask : pop
endmodule : host_model

/* adc_input_and_fifo_control_bench.sv */
// Self-checking bench for control words and sample store
`timescale 1ns/100ps
module adc_input_and_fifo_control_bench;
    import adc_cfg_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic sample_tick = 1'b0;
    logic wr_strobe, rd_strobe, fifo_empty, samples_ready_flag, offset_clear;
    logic [1:0] reg_addr;
    logic [1:0] conv_source;
    logic [2:0] input_mode;
    logic [11:0] wr_data;
    logic [9:0] pa = '0, na = '0, ua = '0, la = '0, rd_data;
    int miscompares = 0;
    int check_count = 0;
    int sel = 0; // Own copy of the write-only word
    int ph = 0;
    int hold = 0;
    int q[$];
    int lv[4] = '{1, 4, 8, 14};
    int wm[5] = '{'h000, 'h008, 'h020, 'h088, 'h010};
    always #2.5 mclk = ~mclk;
    adc_input_and_fifo_control adc_input_and_fifo_control_inst (.mclk(mclk), .rst_n(rst_n),
        .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .reg_addr(reg_addr), .wr_data(wr_data),
        .positive_analog_input(pa), .negative_analog_input(na), .upper_reference_level(ua),
        .lower_reference_level(la), .sample_tick(sample_tick), .rd_data(rd_data),
        .fifo_empty(fifo_empty), .samples_ready_flag(samples_ready_flag),
        .input_mode(input_mode), .conv_source(conv_source), .offset_clear(offset_clear));
    host_model host_model_inst (.mclk(mclk), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
        .reg_addr(reg_addr), .wr_data(wr_data));
    task cyc();
        @(posedge mclk);
        #1;
    endtask : cyc
    task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        check_count++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, s);
        end
    endtask : chk
    // Two cycles per tick so the strobe never toggles twice in one step
    task tick();
        int v;
        int s;
        pa = 10'($urandom);
        na = 10'($urandom);
        ua = 10'($urandom);
        la = 10'($urandom);
        s = (sel >> 8) & 3;
        case ((sel >> 3) & 31)
            0: v = pa;
            1: v = na;
            4: v = (pa - na) & 1023;
            17: begin
                v = ph ? na : pa;
                ph = !ph;
            end
            default: v = -1;
        endcase
        if (v >= 0 && s != 0) v = s == 1 ? ua : s == 2 ? (ua + la) / 2 : la;
        if (v >= 0 && hold == 0) q.push_back(v);
        sample_tick = 1'b1;
        cyc();
        sample_tick = 1'b0;
        cyc();
    endtask : tick
    task drain();
        while (q.size() > 0) begin
            host_model_inst.pop();
            chk("rd_data", rd_data, 16'(q.pop_front()));
        end
        chk("empty", fifo_empty, 1);
    endtask : drain
    task stop_test();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : stop_test
    initial begin
        #100000;
        miscompares++;
        stop_test();
    end
    initial begin
        void'($urandom(44));
        repeat (10) @(posedge mclk);
        #1 rst_n = 1'b1;
        chk("mode", input_mode, 2);
        chk("flag", samples_ready_flag, 0);
        repeat (8) cyc();
        foreach (wm[i]) begin
            host_model_inst.wr(2'h0, 12'(wm[i]));
            sel = wm[i];
            ph = 0;
            chk("mode", input_mode, 16'(i));
            repeat (3) begin
                tick();
                chk("pulse", samples_ready_flag, q.size() == (i == 3 ? 2 : 1));
            end
            drain();
        end
        for (int s = 1; s < 4; s++) begin
            sel = s << 8;
            host_model_inst.wr(2'h0, 12'(sel));
            chk("source", conv_source, 16'(s));
            tick();
            drain();
        end
        sel = 0;
        host_model_inst.wr(2'h0, 12'h000);
        for (int c = 0; c < 4; c++) begin
            host_model_inst.wr(2'h1, 12'h022 | 12'(c << 2));
            repeat (lv[c] - 1) tick();
            chk("flag", samples_ready_flag, 0);
            tick();
            chk("flag", samples_ready_flag, 1);
            drain();
        end
        repeat (3) tick();
        host_model_inst.wr(2'h1, 12'h032);
        q.delete();
        chk("empty", fifo_empty, 1);
        chk("mode", input_mode, 0);
        tick();
        chk("pulse", samples_ready_flag, 1);
        cyc();
        chk("pulse", samples_ready_flag, 0);
        host_model_inst.wr(2'h1, 12'h002);
        chk("low", samples_ready_flag, 1);
        tick();
        chk("low", samples_ready_flag, 0);
        host_model_inst.wr(2'h0, 12'h308);
        tick();
        host_model_inst.wr(2'h1, 12'h001);
        q.delete();
        sel = 'h020;
        chk("mode", input_mode, 2);
        chk("source", conv_source, 0);
        hold = 1;
        repeat (2) tick();
        hold = 0;
        chk("empty", fifo_empty, 1);
        repeat (2) cyc();
        tick();
        drain();
        stop_test();
    end
endmodule : adc_input_and_fifo_control_bench
